// *** rtl/ifc_pkg.sv ***
// package: register map, bit positions and constants of the interrupt block
package ifc_pkg;
  // ==========================================================
  // register indices (byte address = index * 4)
  localparam logic [7:0] IDX_TIMER_ZERO   = 8'h01;
  localparam logic [7:0] IDX_STATUS       = 8'h03;
  localparam logic [7:0] IDX_IO_PORT_A    = 8'h05;
  localparam logic [7:0] IDX_IRQ_CONTROL  = 8'h0B;
  localparam logic [7:0] IDX_PERIPH_FLAG  = 8'h0C;
  localparam logic [7:0] IDX_EDGE_CFG     = 8'h81;
  localparam logic [7:0] IDX_PERIPH_EN    = 8'h8C;
  localparam logic [7:0] IDX_ANALOG_SEL   = 8'h91;
  localparam logic [7:0] IDX_PIN_CHG_MASK = 8'h96;
  // ==========================================================
  // irq_control_reg fields
  localparam int B_GIE   = 7;
  localparam int B_PERIPHERAL_IRQ_GATE  = 6;
  localparam int B_TIMER_ZERO_OVF_ENABLE  = 5;
  localparam int B_EXT_IRQ_ENABLE  = 4;
  localparam int B_PIN_CHANGE_IRQ_ENABLE  = 3;
  localparam int B_TIMER_ZERO_OVF_FLAG  = 2;
  localparam int B_EXT_IRQ_FLAG  = 1;
  localparam int B_PIN_CHANGE_FLAG  = 0;
  localparam logic [7:0] CTRL_FLAG_MASK   = 8'h07;
  // ==========================================================
  // other fields and reset values
  localparam int B_EDGE_SEL              = 6;
  localparam int B_TIMEOUT               = 4;
  localparam int B_POWERDOWN             = 3;
  localparam int EXT_PIN                 = 2;
  localparam logic [7:0] PERIPH_MASK     = 8'h7B;
  localparam logic [7:0] STATUS_RST      = 8'h18;
  localparam logic [7:0] EDGE_CFG_RST    = 8'hFF;
  localparam logic [7:0] ANALOG_SEL_RST  = 8'hFF;
  localparam logic [7:0] ZERO8           = 8'h00;
  localparam logic [7:0] TIMER_MAX       = 8'hFF;
  localparam logic [12:0] VECTOR_ADDR    = 13'h0004;
endpackage

// *** rtl/ifc_edge_detect.sv ***
// selectable edge detector for the external interrupt pin
`timescale 1ns/100ps
module ifc_edge_detect
  import ifc_pkg::*;
(
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  // pin and configuration
  input  wire logic i_level,
  input  wire logic i_rising,
  // event
  output logic      o_edge
);
  logic prev_ff;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= i_level;
    end
  end

  // rising when select is one, falling when zero
  assign o_edge = i_rising ? (i_level & ~prev_ff) : (~i_level & prev_ff);
endmodule

// *** rtl/ifc_change_detect.sv ***
// per-pin change detector for the port change interrupt
`timescale 1ns/100ps
module ifc_change_detect
  import ifc_pkg::*;
#(
  parameter int WIDTH = 6
)(
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_resetn,
  // pins and selection
  input  wire logic [WIDTH-1:0] i_pins,
  input  wire logic [WIDTH-1:0] i_enable,
  input  wire logic             i_port_op,
  // event
  output logic                  o_change
);
  logic [WIDTH-1:0] last_ff;

  // latch follows the pins every cycle so a change is seen once
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      last_ff <= '0;
    end else begin
      last_ff <= i_pins;
    end
  end

  // a port operation in the same cycle swallows the change
  assign o_change = (|((i_pins ^ last_ff) & i_enable)) & ~i_port_op;
endmodule

// *** rtl/ifc_irq_ctrl.sv ***
// interrupt flag controller: flags, enables, vectoring, sleep wake-up
// ==========================================================
// What this block does
// - interrupts are taken only while the global enable is set.
// - any reset clears the global enable.
// - on service clear global enable, push return address, jump 0004h.
// - return-from-interrupt sets the global enable again.
// - flags set on their event whatever their enables say.
// - clearing the global enable holds pending requests until re-enabled.
// - pin or port-change event reaches the vector in three cycles.
// - external pin flag set on rising or falling edge per select bit.
// - external enable clear disables the pin interrupt.
// - pin edge wakes from sleep only if its enable was set beforehand.
// - analog pins read zero and raise no pin or change interrupt.
// - timer-zero wrap from FFh to 00h sets its overflow flag.
// - enabled port pin change sets the change flag, gated per pin.
// - a change during a port operation may not set the flag.
// - control register holds core flags; peripheral flags sit elsewhere.
// - after wake, execute PC+1 first, then vector if globally enabled.
// - interrupt wake-up sets time-out status, clears power-down status.
`timescale 1ns/100ps
module ifc_irq_ctrl
  import ifc_pkg::*;
#(
  parameter int PORT_W = 6,
  parameter int PC_W   = 13
)(
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_resetn,
  // avalon-mm slave
  input  wire logic [9:0]        i_address,
  input  wire logic              i_read,
  input  wire logic              i_write,
  input  wire logic [31:0]       i_writedata,
  output logic [31:0]            o_readdata,
  output logic                   o_waitrequest,
  // pins and event sources
  input  wire logic [PORT_W-1:0] i_io_port_a,
  input  wire logic              i_port_op,
  input  wire logic              i_timer_zero_tick,
  input  wire logic [7:0]        i_periph_event,
  // core sequencer
  input  wire logic [PC_W-1:0]   i_core_pc,
  input  wire logic              i_return_from_irq,
  input  wire logic              i_gie_clear,
  input  wire logic              i_sleep_enter,
  output logic                   o_vector_take,
  output logic [PC_W-1:0]        o_vector_addr,
  output logic [PC_W-1:0]        o_push_addr,
  output logic                   o_wake,
  output logic                   o_sleeping
);
  // ==========================================================
  // registers and helpers
  logic [7:0]        ctrl_ff;
  logic [7:0]        pflag_ff;
  logic [7:0]        pen_ff;
  logic [7:0]        edge_cfg_ff;
  logic [7:0]        analog_ff;
  logic [7:0]        status_ff;
  logic [7:0]        tmr_ff;
  logic [PORT_W-1:0] pcmask_ff;
  logic              ack_ff;
  logic [31:0]       rdata_ff;
  logic              pend_ff;
  logic              vec_ff;
  logic [PC_W-1:0]   push_ff;
  logic              sleep_ff;
  logic              ext_irq_enable_slp_ff;
  logic              wake_ff;
  logic              skip_ff;

  logic [7:0]        idx;
  logic              wr_en;
  logic [7:0]        wd;
  logic [PORT_W-1:0] port_dig;
  logic              ext_edge;
  logic              ext_edge_raw;
  logic              pin_chg;
  logic              tmr_ovf;
  logic [7:0]        nxt_ctrl;
  logic [7:0]        nxt_pflag;
  logic              core_req;
  logic              per_req;
  logic              irq_req;
  logic              wake_src;

  // set wins over a software clear in the same cycle
  function automatic logic [7:0] merge(input logic [7:0] cur,
                                       input logic       wr,
                                       input logic [7:0] wdat,
                                       input logic [7:0] setv);
    merge = (wr ? wdat : cur) | setv;
  endfunction

  assign idx   = i_address[9:2];
  assign wd    = i_writedata[7:0];
  assign wr_en = i_write & ~o_waitrequest;

  // ==========================================================
  // bus slave: one wait cycle, then answer
  assign o_waitrequest = (i_read | i_write) & ~ack_ff;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (i_read | i_write) & ~ack_ff;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_ff <= '0;
    end else if (i_read & ~ack_ff) begin
      case (idx)
        IDX_TIMER_ZERO:   rdata_ff <= {24'h000000, tmr_ff};
        IDX_STATUS:       rdata_ff <= {24'h000000, status_ff};
        IDX_IO_PORT_A:    rdata_ff <= {26'h0000000, port_dig};
        IDX_IRQ_CONTROL:  rdata_ff <= {24'h000000, ctrl_ff};
        IDX_PERIPH_FLAG:  rdata_ff <= {24'h000000, pflag_ff};
        IDX_EDGE_CFG:     rdata_ff <= {24'h000000, edge_cfg_ff};
        IDX_PERIPH_EN:    rdata_ff <= {24'h000000, pen_ff};
        IDX_ANALOG_SEL:   rdata_ff <= {24'h000000, analog_ff};
        IDX_PIN_CHG_MASK: rdata_ff <= {26'h0000000, pcmask_ff};
        default:          rdata_ff <= '0;
      endcase
    end
  end
  assign o_readdata = rdata_ff;

  // ==========================================================
  // plain configuration registers
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pen_ff      <= ZERO8;
      edge_cfg_ff <= EDGE_CFG_RST;
      analog_ff   <= ANALOG_SEL_RST;
      pcmask_ff   <= '0;
    end else if (wr_en) begin
      if (idx == IDX_PERIPH_EN)    pen_ff      <= wd & PERIPH_MASK;
      if (idx == IDX_EDGE_CFG)     edge_cfg_ff <= wd;
      if (idx == IDX_ANALOG_SEL)   analog_ff   <= wd;
      if (idx == IDX_PIN_CHG_MASK) pcmask_ff   <= wd[PORT_W-1:0];
    end
  end

  // ==========================================================
  // event sources
  // analog-selected pins are forced low before any detector
  assign port_dig = i_io_port_a & ~analog_ff[PORT_W-1:0];

  ifc_edge_detect u_edge (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_level   (port_dig[EXT_PIN]),
    .i_rising  (edge_cfg_ff[B_EDGE_SEL]),
    .o_edge    (ext_edge_raw)
  );
  // forcing a pin analog drops its level; that drop must not count as an edge
  assign ext_edge = ext_edge_raw & ~analog_ff[EXT_PIN];

  ifc_change_detect #(.WIDTH(PORT_W)) u_chg (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_pins    (port_dig),
    .i_enable  (pcmask_ff & ~analog_ff[PORT_W-1:0]),
    .i_port_op (i_port_op),
    .o_change  (pin_chg)
  );

  // a software load wins over the tick, so no wrap happens in that cycle
  assign tmr_ovf = i_timer_zero_tick & (tmr_ff == TIMER_MAX)
                 & ~(wr_en && idx == IDX_TIMER_ZERO);

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tmr_ff <= ZERO8;
    end else if (wr_en && idx == IDX_TIMER_ZERO) begin
      tmr_ff <= wd;
    end else if (i_timer_zero_tick) begin
      tmr_ff <= tmr_ff + 8'h01;
    end
  end

  // ==========================================================
  // flag and enable registers
  always_comb begin
    nxt_ctrl = merge(ctrl_ff, wr_en && idx == IDX_IRQ_CONTROL, wd,
                     {5'h00, tmr_ovf, ext_edge, pin_chg});
    if (i_return_from_irq) begin
      nxt_ctrl[B_GIE] = 1'b1;
    end
    if (i_gie_clear | vec_ff) begin
      nxt_ctrl[B_GIE] = 1'b0;
    end
    nxt_pflag = merge(pflag_ff, wr_en && idx == IDX_PERIPH_FLAG, wd,
                      i_periph_event) & PERIPH_MASK;
  end

  // flags are cleared here only by reset; otherwise only software clears them
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_ff  <= ZERO8;
      pflag_ff <= ZERO8;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      pflag_ff <= nxt_pflag;
    end
  end

  // ==========================================================
  // request and vectoring
  assign core_req = (ctrl_ff[B_TIMER_ZERO_OVF_ENABLE] & ctrl_ff[B_TIMER_ZERO_OVF_FLAG])
                  | (ctrl_ff[B_EXT_IRQ_ENABLE] & ctrl_ff[B_EXT_IRQ_FLAG])
                  | (ctrl_ff[B_PIN_CHANGE_IRQ_ENABLE] & ctrl_ff[B_PIN_CHANGE_FLAG]);
  assign per_req  = ctrl_ff[B_PERIPHERAL_IRQ_GATE] & (|(pflag_ff & pen_ff));
  // gated by the global enable; a cleared enable just parks it
  assign irq_req  = ctrl_ff[B_GIE] & (core_req | per_req);

  // two stages after the flag give the fixed three-cycle latency
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_ff <= 1'b0;
      vec_ff  <= 1'b0;
      push_ff <= '0;
    end else begin
      pend_ff <= irq_req & ~sleep_ff & ~i_gie_clear;
      // skip holds one cycle so PC+1 executes after a wake
      vec_ff  <= pend_ff & irq_req & ~vec_ff & ~skip_ff
                 & ~i_gie_clear;
      if (pend_ff & irq_req & ~vec_ff & ~skip_ff & ~i_gie_clear) begin
        push_ff <= i_core_pc;
      end
    end
  end
  assign o_vector_take = vec_ff;
  assign o_vector_addr = VECTOR_ADDR;
  assign o_push_addr   = push_ff;

  // ==========================================================
  // sleep and wake-up
  assign wake_src = (ctrl_ff[B_TIMER_ZERO_OVF_ENABLE] & ctrl_ff[B_TIMER_ZERO_OVF_FLAG])
                  | (ext_irq_enable_slp_ff & ctrl_ff[B_EXT_IRQ_FLAG])
                  | (ctrl_ff[B_PIN_CHANGE_IRQ_ENABLE] & ctrl_ff[B_PIN_CHANGE_FLAG]) | per_req;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sleep_ff    <= 1'b0;
      ext_irq_enable_slp_ff <= 1'b0;
      wake_ff     <= 1'b0;
      skip_ff     <= 1'b0;
    end else begin
      wake_ff <= sleep_ff & wake_src;
      skip_ff <= wake_ff;
      if (i_sleep_enter & ~sleep_ff) begin
        sleep_ff    <= 1'b1;
        ext_irq_enable_slp_ff <= ctrl_ff[B_EXT_IRQ_ENABLE];
      end else if (sleep_ff & wake_src) begin
        sleep_ff <= 1'b0;
      end
    end
  end
  assign o_wake     = wake_ff;
  assign o_sleeping = sleep_ff;

  // sleep entry and interrupt wake both leave time-out 1, power-down 0
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_ff <= STATUS_RST;
    end else if (i_sleep_enter | (sleep_ff & wake_src)) begin
      status_ff[B_TIMEOUT]   <= 1'b1;
      status_ff[B_POWERDOWN] <= 1'b0;
    end else if (wr_en && idx == IDX_STATUS) begin
      status_ff <= {wd[7:5], status_ff[B_TIMEOUT:B_POWERDOWN], wd[2:0]};
    end
  end

  // ==========================================================
  // checks
  sequence s_req_held;
    irq_req & ~sleep_ff & ~skip_ff & ~i_gie_clear & ~vec_ff;
  endsequence

  AST_GIE_GATES: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    vec_ff |-> $past(ctrl_ff[B_GIE]))
    else $error("vector taken without global enable");
  AST_VEC_CLEARS_GIE: assert property (@(posedge i_ref_clk)
    disable iff (!i_resetn) vec_ff & ~i_return_from_irq |=> !ctrl_ff[B_GIE])
    else $error("global enable not cleared on vector");
  AST_RETURN_SETS: assert property (@(posedge i_ref_clk)
    disable iff (!i_resetn) i_return_from_irq & ~i_gie_clear & ~vec_ff
    |=> ctrl_ff[B_GIE])
    else $error("return did not set global enable");
  AST_TMR_FLAG: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    tmr_ovf |=> ctrl_ff[B_TIMER_ZERO_OVF_FLAG] && tmr_ff == ZERO8)
    else $error("timer wrap did not set its flag");
  AST_EXT_FLAG: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    ext_edge |=> ctrl_ff[B_EXT_IRQ_FLAG])
    else $error("pin edge lost");
  AST_LATENCY: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    s_req_held ##1 s_req_held |=> vec_ff)
    else $error("vector late after request");
  AST_GIE_CLEAR_HOLD: assert property (@(posedge i_ref_clk)
    disable iff (!i_resetn) i_gie_clear |=> !vec_ff ##1 !vec_ff)
    else $error("vector taken after global enable cleared");
  AST_WAKE_STATUS: assert property (@(posedge i_ref_clk)
    disable iff (!i_resetn) sleep_ff & wake_src
    |=> status_ff[B_TIMEOUT] && !status_ff[B_POWERDOWN] && wake_ff)
    else $error("wake status wrong");
  AST_WAKE_SKIP: assert property (@(posedge i_ref_clk)
    disable iff (!i_resetn) wake_ff |=> !vec_ff ##1 !vec_ff)
    else $error("vector before PC+1 after wake");
  AST_ANALOG_ZERO: assert property (@(posedge i_ref_clk)
    disable iff (!i_resetn) i_read & ~o_waitrequest & (idx == IDX_IO_PORT_A)
    |-> (o_readdata[PORT_W-1:0] & analog_ff[PORT_W-1:0]) == '0)
    else $error("analog pin reads nonzero");
endmodule

// *** verif/ifc_core_model.sv ***
// processor core model: program counter, return stack, return request
`timescale 1ns/100ps
module ifc_core_model
  import ifc_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  // from the interrupt block
  input  wire logic        i_vector_take,
  input  wire logic [12:0] i_vector_addr,
  input  wire logic [12:0] i_push_addr,
  // return request from the bench
  input  wire logic        i_ret_req,
  // to the interrupt block
  output logic [12:0]      o_core_pc,
  output logic             o_return_from_irq
);
  // ==========================================================
  // sequencer
  // one-deep stack is enough: the bench never nests service routines
  logic [12:0] stack_ff;
  assign o_return_from_irq = i_ret_req;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_core_pc <= 13'h0000;
      stack_ff  <= 13'h0000;
    end else if (i_vector_take) begin
      stack_ff  <= i_push_addr;
      o_core_pc <= i_vector_addr;
    end else if (i_ret_req) begin
      o_core_pc <= stack_ff;
    end else begin
      o_core_pc <= o_core_pc + 13'h0001;
    end
  end
endmodule

// *** verif/tb.sv ***
// bench for the interrupt flag controller
`timescale 1ns/100ps
module tb;
  import ifc_pkg::*;
  typedef struct packed {
    logic       w;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } ifc_row_s;
  // ==========================================================
  // signals
  logic        clk, rstn, rd, wr, wreq, port_op, tick;
  logic        gclr, slp, ret, ret_w, vt, wake, sleeping;
  logic [9:0]  addr;
  logic [31:0] wdata, rdata;
  logic [5:0]  port;
  logic [7:0]  pev, r;
  logic [12:0] pc, va, pa, pc2;
  int          err_total, comparisons, k, wk;
  // reset values, masked widths, reserved bits, read-only and unmapped
  ifc_row_s rows [14] = '{
    '{1'h0, 8'h0B, 8'h00, 8'h00}, '{1'h0, 8'h0C, 8'h00, 8'h00},
    '{1'h0, 8'h81, 8'h00, 8'hFF}, '{1'h0, 8'h8C, 8'h00, 8'h00},
    '{1'h0, 8'h91, 8'h00, 8'hFF}, '{1'h0, 8'h96, 8'h00, 8'h00},
    '{1'h0, 8'h03, 8'h00, 8'h18}, '{1'h0, 8'h01, 8'h00, 8'h00},
    '{1'h0, 8'h05, 8'h00, 8'h00}, '{1'h1, 8'h96, 8'hFF, 8'h3F},
    '{1'h1, 8'h8C, 8'hFF, 8'h7B}, '{1'h1, 8'h40, 8'hFF, 8'h00},
    '{1'h1, 8'h03, 8'h00, 8'h18}, '{1'h1, 8'h96, 8'h00, 8'h00}};
  ifc_irq_ctrl dut_u (
    .i_ref_clk(clk), .i_resetn(rstn), .i_address(addr), .i_read(rd),
    .i_write(wr), .i_writedata(wdata), .o_readdata(rdata),
    .o_waitrequest(wreq), .i_io_port_a(port), .i_port_op(port_op),
    .i_timer_zero_tick(tick), .i_periph_event(pev), .i_core_pc(pc),
    .i_return_from_irq(ret_w), .i_gie_clear(gclr), .i_sleep_enter(slp),
    .o_vector_take(vt), .o_vector_addr(va), .o_push_addr(pa),
    .o_wake(wake), .o_sleeping(sleeping));
  ifc_core_model core_u (
    .i_ref_clk(clk), .i_resetn(rstn), .i_vector_take(vt),
    .i_vector_addr(va), .i_push_addr(pa), .i_ret_req(ret),
    .o_core_pc(pc), .o_return_from_irq(ret_w));
  // ==========================================================
  // tasks
  task automatic finish_test;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] idx, wd,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= {idx, 2'h0};
    rd <= !w;
    wr <= w;
    wdata <= {24'h000000, wd};
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'h0 && n < 20);
    if (wreq !== 1'h0) begin
      err_total++;
      finish_test();
    end
    q = rdata[7:0];
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task automatic rdchk(input logic [7:0] idx, exp);
    bus(1'h0, idx, 8'h00, r);
    chk($sformatf("reg_%h", idx), {8'h00, exp}, {8'h00, r});
  endtask
  task automatic setport(input logic [5:0] v);
    @(posedge clk);
    port <= v;
  endtask
  // one-cycle pulses; vwait drops them at its first edge
  task automatic hit(input logic [2:0] m, input logic [7:0] e);
    @(posedge clk);
    {ret, gclr, slp} <= m;
    pev <= e;
  endtask
  // edges until a vector (99 if none), and edge of the first wake pulse
  task automatic vwait(input int mx, output int c, output int w);
    c = 0;
    w = 99;
    do begin
      @(posedge clk);
      {ret, gclr, slp} <= 3'h0;
      pev <= 8'h00;
      #1;
      c++;
      if (c == 2)
        pc2 = pc;
      if (wake === 1'h1 && w == 99)
        w = c;
    end while (vt !== 1'h1 && c < mx);
    if (vt !== 1'h1)
      c = 99;
  endtask
  // ==========================================================
  // clock and watchdog
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    finish_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    {rstn, rd, wr, port_op, tick, gclr, slp, ret} = 8'h00;
    addr = 10'h000;
    wdata = 32'h00000000;
    port = 6'h3F;
    pev = 8'h00;
    err_total = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].w)
        bus(1'h1, rows[i].idx, rows[i].wd, r);
      rdchk(rows[i].idx, rows[i].exp);
    end
    bus(1'h1, IDX_ANALOG_SEL, 8'h00, r);
    for (int s = 0; s < 2; s++) begin
      bus(1'h1, IDX_EDGE_CFG, s ? 8'h40 : 8'h00, r);
      bus(1'h1, IDX_IRQ_CONTROL, 8'h00, r);
      setport(6'h3B);
      rdchk(IDX_IRQ_CONTROL, s ? 8'h00 : 8'h02);
      bus(1'h1, IDX_IRQ_CONTROL, 8'h00, r);
      setport(6'h3F);
      rdchk(IDX_IRQ_CONTROL, s ? 8'h02 : 8'h00);
    end
    bus(1'h1, IDX_IRQ_CONTROL, 8'h00, r);
    bus(1'h1, IDX_EDGE_CFG, 8'h00, r);
    bus(1'h1, IDX_ANALOG_SEL, 8'h04, r);
    setport(6'h3B);
    setport(6'h3F);
    rdchk(IDX_IO_PORT_A, 8'h3B);
    rdchk(IDX_IRQ_CONTROL, 8'h00);
    bus(1'h1, IDX_EDGE_CFG, 8'h40, r);
    bus(1'h1, IDX_ANALOG_SEL, 8'h00, r);
    setport(6'h3B);
    bus(1'h1, IDX_IRQ_CONTROL, 8'h90, r);
    setport(6'h3F);
    vwait(8, k, wk);
    chk("latency", 16'h0003, 16'(k));
    chk("push", {3'h0, pc2}, {3'h0, pa});
    chk("vector", 16'h0004, {3'h0, va});
    rdchk(IDX_IRQ_CONTROL, 8'h12);
    vwait(8, k, wk);
    chk("blocked", 16'h0063, 16'(k));
    hit(3'h4, 8'h00);
    vwait(8, k, wk);
    chk("repeat", 16'h0001, 16'(k < 8));
    bus(1'h1, IDX_IRQ_CONTROL, 8'h10, r);
    hit(3'h4, 8'h00);
    vwait(8, k, wk);
    chk("cleared", 16'h0063, 16'(k));
    rdchk(IDX_IRQ_CONTROL, 8'h90);
    setport(6'h3B);
    setport(6'h3F);
    hit(3'h2, 8'h00);
    vwait(6, k, wk);
    chk("held", 16'h0063, 16'(k));
    rdchk(IDX_IRQ_CONTROL, 8'h12);
    hit(3'h4, 8'h00);
    vwait(8, k, wk);
    chk("resumed", 16'h0001, 16'(k < 8));
    bus(1'h1, IDX_IRQ_CONTROL, 8'h20, r);
    @(posedge clk);
    tick <= 1'h1;
    repeat (255) @(posedge clk);
    tick <= 1'h0;
    rdchk(IDX_TIMER_ZERO, 8'hFF);
    rdchk(IDX_IRQ_CONTROL, 8'h20);
    @(posedge clk);
    tick <= 1'h1;
    @(posedge clk);
    tick <= 1'h0;
    rdchk(IDX_TIMER_ZERO, 8'h00);
    rdchk(IDX_IRQ_CONTROL, 8'h24);
    bus(1'h1, IDX_IRQ_CONTROL, 8'h08, r);
    bus(1'h1, IDX_PIN_CHG_MASK, 8'h01, r);
    setport(6'h3D);
    rdchk(IDX_IRQ_CONTROL, 8'h08);
    setport(6'h3C);
    rdchk(IDX_IRQ_CONTROL, 8'h09);
    bus(1'h1, IDX_IRQ_CONTROL, 8'h08, r);
    @(posedge clk);
    port <= 6'h3D;
    port_op <= 1'h1;
    @(posedge clk);
    port_op <= 1'h0;
    // a flag missed here is tolerated, so it is only cleared
    bus(1'h1, IDX_IRQ_CONTROL, 8'h00, r);
    bus(1'h1, IDX_PERIPH_EN, 8'h01, r);
    hit(3'h0, 8'h01);
    vwait(1, k, wk);
    rdchk(IDX_PERIPH_FLAG, 8'h01);
    bus(1'h1, IDX_IRQ_CONTROL, 8'h80, r);
    vwait(8, k, wk);
    chk("no_gate", 16'h0063, 16'(k));
    bus(1'h1, IDX_IRQ_CONTROL, 8'hC0, r);
    vwait(8, k, wk);
    chk("gated", 16'h0001, 16'(k < 8));
    bus(1'h1, IDX_PERIPH_FLAG, 8'h00, r);
    bus(1'h1, IDX_IRQ_CONTROL, 8'h90, r);
    setport(6'h3B);
    hit(3'h1, 8'h00);
    vwait(2, k, wk);
    chk("asleep", 16'h0001, {15'h0000, sleeping});
    setport(6'h3F);
    vwait(10, k, wk);
    chk("wake", 16'h0002, 16'(wk));
    chk("wake_vec", 16'h0001, 16'(k >= 4 && k <= 8));
    rdchk(IDX_STATUS, 8'h10);
    bus(1'h1, IDX_IRQ_CONTROL, 8'h00, r);
    setport(6'h3B);
    hit(3'h1, 8'h00);
    vwait(2, k, wk);
    bus(1'h1, IDX_IRQ_CONTROL, 8'h90, r);
    setport(6'h3F);
    vwait(8, k, wk);
    chk("no_wake", 16'h0063, 16'(wk));
    @(posedge clk);
    rstn <= 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    rdchk(IDX_IRQ_CONTROL, 8'h00);
    chk("awake", 16'h0000, {15'h0000, sleeping});
    finish_test();
  end
endmodule
